// file: core/ir_temp_alert_and_nvm_control.sv
// alert flags, output filter, transient correction and nonvolatile store
// Notes on behaviour
// - correction adds weighted die and voltage slopes
// - filter final is 0.2 raw plus 0.8 old
// - zero weights leave voltage unmodified, filter stays
// - filter step time constant about five samples
// - window mode flags set on limit crossing
// - alert pin driven only when gate set
// - window flags held until status read, pin until read or alert response
// - window-mode alert response releases pin, flags stay
// - comparator high flag with low-limit hysteresis
// - comparator ignores low enables, low flags zero
// - comparator updates only at conversion end
// - store keeps values, eight writes, else defaults
// - loads on reset, general and single load
// - writes-remaining code per location store count
// - store without key is ignored
// - load lasts 3 ms, no acknowledge meanwhile
// - requested load aborts conversion, registers writable after
// - store replaces older value of location
// - alert answer lsb shows high or low
// - general call reset triggers a memory load
`default_nettype none
`include "ir_alert_params.svh"
module ir_temp_alert_and_nvm_control #(
    parameter int LOAD_CYCLES = `LOAD_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire ir_alert_pkg::reg_req_t reg_req,
    output logic [15:0]                 reg_rdata,
    output logic                        reg_ack,
    output logic                        bus_busy,
    input  wire ir_alert_pkg::meas_t    meas,
    input  wire ir_alert_pkg::conv_t    conv,
    output logic [15:0]                 thermopile_voltage,
    output logic                        corr_valid,
    output logic                        conv_abort,
    output logic                        conv_restart,
    input  wire logic                   gcall_reset,
    input  wire logic                   ara_req,
    input  wire logic                   ara_won,
    output logic                        ara_ack,
    output logic                        ara_lsb,
    output logic                        alert_n
);
    localparam logic [19:0] TIMER_TOP = 20'(LOAD_CYCLES - 1);

    ir_alert_pkg::state_t st_r;
    ir_alert_pkg::state_t st_nxt;

    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic writable(input logic [4:0] a);
        writable = (a == `REG_CONFIG) || (a == `REG_MASK) ||
                   (a >= `REG_OBJ_HI && a <= `REG_VOLT_SLOPE_W);
    endfunction

    // factory value of a location that was never stored
    function automatic logic [15:0] dflt(input logic [4:0] a);
        case (a)
            `REG_CONFIG:      dflt = `RST_CONFIG;
            `REG_OBJ_HI:      dflt = `RST_OBJ_HI;
            `REG_OBJ_LO:      dflt = `RST_OBJ_LO;
            `REG_DIE_HI:      dflt = `RST_DIE_HI;
            `REG_DIE_LO:      dflt = `RST_DIE_LO;
            5'h0A:            dflt = `RST_S0;
            5'h0B:            dflt = `RST_A1;
            5'h0C:            dflt = `RST_A2;
            5'h0D:            dflt = `RST_B0;
            5'h0E:            dflt = `RST_B1;
            5'h0F:            dflt = `RST_B2;
            `REG_DIE_SLOPE_W: dflt = `RST_DIE_SLOPE_W;
            default:          dflt = 16'h0000;
        endcase
    endfunction

    // limit holds the top ten temperature bits
    function automatic logic above(input logic [13:0] t,
                                   input logic [15:0] lim);
        above = $signed(t[13:4]) > $signed(lim[15:6]);
    endfunction

    function automatic logic below(input logic [13:0] t,
                                   input logic [15:0] lim);
        below = $signed(t[13:4]) < $signed(lim[15:6]);
    endfunction

    // zero or one store both read 000, then one per store
    function automatic logic [2:0] writes_remaining_code(input logic [3:0] c);
        writes_remaining_code = (c <= 4'h1) ? 3'h0 : 3'(c - 4'h1);
    endfunction

    function automatic logic [15:0] wslope(input logic [15:0] w,
                                           input logic [16:0] d);
        logic signed [32:0] p;
        p = $signed(w) * $signed(d);
        wslope = 16'(p >>> `SLOPE_SHIFT);
    endfunction

    // ****************************************
    // access decode
    // ****************************************
    logic        run;
    logic        wr;
    logic        rd;
    logic [4:0]  ra;
    logic        in_array;
    logic        comp_mode;
    logic        tc_on;
    logic [15:0] msk;
    logic        key_ok;
    logic        stat_rd;
    logic [15:0] rd_val;

    assign run       = (st_r.st == ir_alert_pkg::ST_RUN);
    assign wr        = run & reg_req.wr;
    assign rd        = run & reg_req.rd & ~reg_req.wr;
    assign ra        = reg_req.addr[4:0];
    assign in_array  = reg_req.addr <= `REG_ARRAY_TOP;
    assign comp_mode = st_r.regs[`REG_CONFIG][`CFG_ALERT_MODE];
    assign tc_on     = st_r.regs[`REG_CONFIG][`CFG_TC_ON];
    assign msk       = st_r.regs[`REG_MASK];
    assign key_ok    = reg_req.wdata[15:8] == `NV_KEY;
    assign stat_rd   = rd & in_array & (ra == `REG_STATUS);

    // read mux; low flags forced to zero in comparator mode
    always_comb begin
        rd_val = 16'h0000;
        if (reg_req.addr == `REG_NV_CTRL) begin
            rd_val = {4'h0, writes_remaining_code(st_r.cnt[st_r.nv_addr]), 1'b0,
                      st_r.nv_addr, 3'h0};
        end else if (in_array) begin
            unique case (ra)
                `REG_STATUS: begin
                    rd_val[`ST_ALERT]     = ~st_r.alert_n;
                    rd_val[`ST_OBJ_HI]    = st_r.obj_hi;
                    rd_val[`ST_OBJ_LO]    = st_r.obj_lo & ~comp_mode;
                    rd_val[`ST_DIE_HI]    = st_r.die_hi;
                    rd_val[`ST_DIE_LO]    = st_r.die_lo & ~comp_mode;
                    rd_val[`ST_NOT_VALID] = st_r.not_valid;
                    rd_val[`ST_OVERFLOW]  = st_r.overflow;
                end
                `REG_OBJ:
                    rd_val = {st_r.obj_final, 1'b0, st_r.not_valid};
                default: rd_val = st_r.regs[ra];
            endcase
        end
    end

    // ****************************************
    // next state
    // ****************************************
    logic        load_all;
    logic        load_one;
    logic [4:0]  tgt;
    logic [16:0] dd;
    logic [16:0] dv;
    logic [16:0] fsum;
    logic        hi_o;
    logic        lo_o;
    logic        hi_d;
    logic        lo_d;
    logic        pwr_load;

    always_comb begin
        st_nxt       = st_r;
        load_all     = 1'b0;
        load_one     = 1'b0;
        tgt          = reg_req.wdata[7:3];
        dd           = 17'h00000;
        dv           = 17'h00000;
        fsum         = 17'h00000;
        hi_o         = 1'b0;
        lo_o         = 1'b0;
        hi_d         = 1'b0;
        lo_d         = 1'b0;
        pwr_load     = !run && st_r.timer == TIMER_TOP && !st_r.conv_abort;
        st_nxt.ack          = 1'b0;
        st_nxt.corr_valid   = 1'b0;
        st_nxt.conv_abort   = 1'b0;
        st_nxt.conv_restart = 1'b0;
        st_nxt.ara_ack      = 1'b0;

        // busy window countdown from own clock
        if (!run) begin
            if (st_r.timer == 20'h00000) begin
                st_nxt.st           = ir_alert_pkg::ST_RUN;
                st_nxt.conv_restart = 1'b1;
            end else begin
                st_nxt.timer = st_r.timer - 20'h00001;
            end
        end

        // register writes and reads
        if (wr) begin
            st_nxt.ack = 1'b1;
            if (in_array && writable(ra)) begin
                st_nxt.regs[ra] = reg_req.wdata;
            end
            if (in_array && ra == `REG_CONFIG &&
                reg_req.wdata[`CFG_SOFT_RST]) begin
                st_nxt.regs[`REG_CONFIG][`CFG_SOFT_RST] = 1'b0;
                load_all = 1'b1;
            end
            if (reg_req.addr == `REG_NV_CTRL && key_ok) begin
                st_nxt.nv_addr = tgt;
                if (reg_req.wdata[`NV_STORE] && writable(tgt) &&
                    st_r.cnt[tgt] < `NV_MAX_STORES) begin
                    st_nxt.nvm[tgt]    = st_r.regs[tgt];
                    st_nxt.nvm_ok[tgt] = 1'b1;
                    st_nxt.cnt[tgt]    = st_r.cnt[tgt] + 4'h1;
                end
                load_all = load_all | reg_req.wdata[`NV_GLOAD];
                load_one = reg_req.wdata[`NV_SLOAD] & writable(tgt);
            end
        end else if (rd) begin
            st_nxt.ack   = 1'b1;
            st_nxt.rdata = rd_val;
        end
        load_all = load_all | gcall_reset;

        // copy the image into the registers; the power-on load has no
        // abort pulse, which keeps it apart from a requested load
        if (load_all || load_one || pwr_load) begin
            for (int i = 0; i < 32; i++) begin
                if (writable(5'(i)) &&
                    (load_all || pwr_load || 5'(i) == tgt)) begin
                    st_nxt.regs[i] = st_nxt.nvm_ok[i] ?
                                     st_nxt.nvm[i] : dflt(5'(i));
                end
            end
        end
        // open the busy window
        if (load_all || load_one) begin
            st_nxt.st           = ir_alert_pkg::ST_LOAD;
            st_nxt.timer        = TIMER_TOP;
            st_nxt.conv_abort   = 1'b1;
            st_nxt.conv_restart = 1'b0;
            st_nxt.have_prev    = 1'b0;
            st_nxt.filt_ok      = 1'b0;
        end

        // transient correction of the sensor voltage
        if (run && meas.valid && !load_all && !load_one) begin
            dd = 17'($signed(meas.die) - $signed(st_r.prev_die));
            dv = 17'($signed(meas.volt) - $signed(st_r.prev_volt));
            st_nxt.regs[`REG_VOLT] = meas.volt;
            st_nxt.regs[`REG_DIE]  = {meas.die, 2'b00};
            st_nxt.prev_die        = meas.die;
            st_nxt.prev_volt       = meas.volt;
            st_nxt.have_prev       = 1'b1;
            st_nxt.corr_valid      = 1'b1;
            st_nxt.corr_volt       = meas.volt;
            // zero weights give zero products, so raw volts pass
            if (tc_on && st_r.have_prev) begin
                st_nxt.corr_volt = meas.volt +
                    wslope(st_r.regs[`REG_DIE_SLOPE_W], dd) +
                    wslope(st_r.regs[`REG_VOLT_SLOPE_W], dv);
            end
        end

        // status read clears window flags; a new event still wins
        if (stat_rd && !comp_mode) begin
            st_nxt.obj_hi = 1'b0;
            st_nxt.obj_lo = 1'b0;
            st_nxt.die_hi = 1'b0;
            st_nxt.die_lo = 1'b0;
            st_nxt.latch  = 1'b0;
        end
        if (ara_won && !comp_mode) begin
            st_nxt.latch = 1'b0;
        end

        // end of conversion: filter, then limit flags
        if (run && conv.done && !load_all && !load_one) begin
            st_nxt.not_valid = conv.not_valid;
            st_nxt.overflow  = conv.overflow;
            st_nxt.obj_final = conv.obj;
            st_nxt.filt_ok   = 1'b1;
            if (tc_on && st_r.filt_ok) begin
                // (raw + 4 old) / 5, a five-sample time constant
                fsum = 17'($signed(conv.obj)) +
                       17'($signed({st_r.obj_final, 2'b00}));
                st_nxt.obj_final = 14'($signed(fsum) / 17'sd5);
            end
            hi_o = above(st_nxt.obj_final, st_r.regs[`REG_OBJ_HI]);
            lo_o = below(st_nxt.obj_final, st_r.regs[`REG_OBJ_LO]);
            hi_d = above(st_r.regs[`REG_DIE][15:2],
                         st_r.regs[`REG_DIE_HI]);
            lo_d = below(st_r.regs[`REG_DIE][15:2],
                         st_r.regs[`REG_DIE_LO]);
            if (comp_mode) begin
                st_nxt.obj_hi = msk[`MSK_OBJ_HI_EN] &
                    (hi_o | (st_r.obj_hi & ~lo_o));
                st_nxt.die_hi = msk[`MSK_DIE_HI_EN] &
                    (hi_d | (st_r.die_hi & ~lo_d));
                st_nxt.obj_lo = 1'b0;
                st_nxt.die_lo = 1'b0;
            end else begin
                hi_o = hi_o & msk[`MSK_OBJ_HI_EN];
                lo_o = lo_o & msk[`MSK_OBJ_LO_EN];
                hi_d = hi_d & msk[`MSK_DIE_HI_EN];
                lo_d = lo_d & msk[`MSK_DIE_LO_EN];
                st_nxt.obj_hi = st_nxt.obj_hi | hi_o;
                st_nxt.obj_lo = st_nxt.obj_lo | lo_o;
                st_nxt.die_hi = st_nxt.die_hi | hi_d;
                st_nxt.die_lo = st_nxt.die_lo | lo_d;
                st_nxt.latch  = st_nxt.latch | hi_o | lo_o | hi_d | lo_d;
            end
        end

        // answer an alert response while the pin is active
        if (ara_req && !st_r.alert_n) begin
            st_nxt.ara_ack = 1'b1;
            st_nxt.ara_lsb = st_r.obj_hi | st_r.die_hi;
        end

        // pin follows flags in comparator mode, the latch otherwise
        st_nxt.alert_n = ~(st_nxt.regs[`REG_CONFIG][`CFG_PIN_GATE] &
            (st_nxt.regs[`REG_CONFIG][`CFG_ALERT_MODE] ?
             (st_nxt.obj_hi | st_nxt.die_hi) : st_nxt.latch));
    end

    // ****************************************
    // state register
    // ****************************************
    // the store is cleared only by the power-on reset input
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_r <= '{st: ir_alert_pkg::ST_LOAD, timer: TIMER_TOP,
                      alert_n: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata          = st_r.rdata;
    assign reg_ack            = st_r.ack;
    assign bus_busy           = (st_r.st == ir_alert_pkg::ST_LOAD);
    assign thermopile_voltage = st_r.corr_volt;
    assign corr_valid         = st_r.corr_valid;
    assign conv_abort         = st_r.conv_abort;
    assign conv_restart       = st_r.conv_restart;
    assign ara_ack            = st_r.ara_ack;
    assign ara_lsb            = st_r.ara_lsb;
    assign alert_n            = st_r.alert_n;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // the load request itself is acked in the first busy cycle
    sequence s_load_start;
        conv_abort && bus_busy;
    endsequence
    sequence s_busy_hold;
        (bus_busy && !reg_ack) [*8];
    endsequence

    property p_load_busy;
        s_load_start |=> s_busy_hold;
    endproperty
    a_load_busy: assert property (p_load_busy)
        else $error("load did not hold the bus busy");

    property p_load_abort;
        $rose(bus_busy) |-> conv_abort;
    endproperty
    a_load_abort: assert property (p_load_abort)
        else $error("load began without conversion abort");

    property p_load_end;
        $fell(bus_busy) |-> conv_restart;
    endproperty
    a_load_end: assert property (p_load_end)
        else $error("load ended without conversion restart");

    property p_pin_gate;
        !st_r.regs[`REG_CONFIG][`CFG_PIN_GATE] |-> alert_n;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("alert pin active while gate clear");

    property p_stat_clear;
        stat_rd && !comp_mode && !conv.done |=> alert_n && !st_r.obj_hi;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status read did not clear window alert");

    property p_ara_keep;
        ara_won && !comp_mode && !stat_rd && !conv.done && !gcall_reset
        |=> alert_n && st_r.obj_hi == $past(st_r.obj_hi);
    endproperty
    a_ara_keep: assert property (p_ara_keep)
        else $error("alert response mishandled pin or flag");

    property p_comp_low;
        stat_rd && comp_mode |=> !reg_rdata[`ST_OBJ_LO] &&
                                 !reg_rdata[`ST_DIE_LO];
    endproperty
    a_comp_low: assert property (p_comp_low)
        else $error("low flag read nonzero in comparator mode");

    property p_comp_hold;
        comp_mode && !conv.done && !gcall_reset |=> $stable(st_r.obj_hi);
    endproperty
    a_comp_hold: assert property (p_comp_hold)
        else $error("comparator flag changed outside conversion end");

    property p_key;
        wr && reg_req.addr == `REG_NV_CTRL && !key_ok |=> $stable(st_r.nvm);
    endproperty
    a_key: assert property (p_key)
        else $error("store without key changed the image");

    property p_ara_lsb;
        ara_req && !alert_n |=> ara_ack &&
            ara_lsb == ($past(st_r.obj_hi) | $past(st_r.die_hi));
    endproperty
    a_ara_lsb: assert property (p_ara_lsb)
        else $error("alert answer wrong cause bit");
endmodule
`default_nettype wire

// file: core/ir_alert_params.svh
// constants for the alert, filter and nonvolatile store block
`ifndef IR_ALERT_PARAMS_SVH
`define IR_ALERT_PARAMS_SVH
// ****************************************
// register indices (5-bit array index; NV control and array top are 8-bit addresses)
// ****************************************
`define REG_VOLT        5'h00
`define REG_DIE         5'h01
`define REG_CONFIG      5'h02
`define REG_OBJ         5'h03
`define REG_STATUS      5'h04
`define REG_MASK        5'h05
`define REG_OBJ_HI      5'h06
`define REG_OBJ_LO      5'h07
`define REG_DIE_HI      5'h08
`define REG_DIE_LO      5'h09
`define REG_DIE_SLOPE_W 5'h11
`define REG_VOLT_SLOPE_W 5'h12
`define REG_NV_CTRL     8'h2A
`define REG_ARRAY_TOP   8'h1F
// ****************************************
// reset values
// ****************************************
`define RST_CONFIG      16'h1440
`define RST_OBJ_HI      16'h7FC0
`define RST_OBJ_LO      16'h8000
`define RST_DIE_HI      16'h7FC0
`define RST_DIE_LO      16'h8000
`define RST_S0          16'h260E
`define RST_A1          16'h0106
`define RST_A2          16'hFF9B
`define RST_B0          16'hFF3A
`define RST_B1          16'hFF71
`define RST_B2          16'h0553
`define RST_DIE_SLOPE_W 16'h0034
// ****************************************
// field positions
// ****************************************
`define CFG_SOFT_RST    15
`define CFG_PIN_GATE    8
`define CFG_TC_ON       6
`define CFG_ALERT_MODE  5
`define MSK_OBJ_HI_EN   13
`define MSK_OBJ_LO_EN   12
`define MSK_DIE_HI_EN   11
`define MSK_DIE_LO_EN   10
`define ST_ALERT        15
`define ST_OBJ_HI       13
`define ST_OBJ_LO       12
`define ST_DIE_HI       11
`define ST_DIE_LO       10
`define ST_NOT_VALID    9
`define ST_OVERFLOW     7
`define NV_KEY          8'h6A
`define NV_GLOAD        0
`define NV_STORE        1
`define NV_SLOAD        2
`define NV_MAX_STORES   4'h8
`define SLOPE_SHIFT     8
// ****************************************
// timing
// ****************************************
`define CLK_MHZ         200
`define LOAD_TIME_US    3000
`define LOAD_CYCLES     (`LOAD_TIME_US * `CLK_MHZ)
`endif

// file: core/ir_alert_pkg.sv
// types for the alert, filter and nonvolatile store block
`default_nettype none
package ir_alert_pkg;
    typedef enum logic {ST_RUN, ST_LOAD} mode_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic        valid;
        logic [13:0] die;
        logic [15:0] volt;
    } meas_t;
    typedef struct packed {
        logic        done;
        logic [13:0] obj;
        logic        not_valid;
        logic        overflow;
    } conv_t;
    typedef struct packed {
        mode_t              st;
        logic [19:0]        timer;
        logic [31:0][15:0]  regs;
        logic [31:0][15:0]  nvm;
        logic [31:0]        nvm_ok;
        logic [31:0][3:0]   cnt;
        logic [4:0]         nv_addr;
        logic               obj_hi;
        logic               obj_lo;
        logic               die_hi;
        logic               die_lo;
        logic               latch;
        logic               not_valid;
        logic               overflow;
        logic [13:0]        obj_final;
        logic               filt_ok;
        logic [13:0]        prev_die;
        logic [15:0]        prev_volt;
        logic               have_prev;
        logic [15:0]        rdata;
        logic               ack;
        logic               alert_n;
        logic [15:0]        corr_volt;
        logic               corr_valid;
        logic               conv_abort;
        logic               conv_restart;
        logic               ara_ack;
        logic               ara_lsb;
    } state_t;
endpackage
`default_nettype wire

// file: tb/bus_host_model.sv
// register request driver standing in for the serial host
`default_nettype none
module bus_host_model (
    input  wire logic                core_clk,
    input  wire logic                reg_ack,
    output var ir_alert_pkg::reg_req_t reg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // request driver
    // ****************************************
    initial reg_req = '0;
    // one-cycle request; lines flip after release so stale data never matches
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] d, output logic ok);
        @(posedge core_clk);
        reg_req <= '{w, !w, a, d};
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
        #1;
        ok = reg_ack;
    endtask
endmodule
`default_nettype wire

// file: tb/ir_temp_alert_and_nvm_control_tb.sv
// self-checking bench for the alert, filter and store block
`default_nettype none
module ir_temp_alert_and_nvm_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LC = 20; // short load window keeps the run brief
    logic core_clk, reset, gcall_reset, ara_req, ara_won, ok;
    logic reg_ack, bus_busy, corr_valid, conv_abort, conv_restart;
    logic ara_ack, ara_lsb, alert_n;
    logic [15:0] reg_rdata, thermopile_voltage;
    ir_alert_pkg::reg_req_t reg_req;
    ir_alert_pkg::meas_t    meas;
    ir_alert_pkg::conv_t    conv;
    int error_cnt = 0, cmp_count = 0, cyc = 0, n, p, raw, w;
    ir_temp_alert_and_nvm_control #(.LOAD_CYCLES(LC))
        i_ir_temp_alert_and_nvm_control (.core_clk, .reset, .reg_req,
        .reg_rdata, .reg_ack, .bus_busy, .meas, .conv, .thermopile_voltage,
        .corr_valid, .conv_abort, .conv_restart, .gcall_reset, .ara_req,
        .ara_won, .ara_ack, .ara_lsb, .alert_n);
    bus_host_model i_bus_host_model (.core_clk, .reg_ack, .reg_req);
    // ****************************************
    // clock, watchdog and helpers
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // a hang ends the run as a mismatch
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_bus_host_model.acc(1'b1, a, d, ok);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        i_bus_host_model.acc(1'b0, a, 16'h0000, ok);
        chk(reg_rdata, e);
    endtask
    task automatic cv(input logic [13:0] o);
        @(posedge core_clk);
        conv <= '{1'b1, o, 1'b0, 1'b0};
        @(posedge core_clk);
        conv.done <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic ara(input logic won);
        @(posedge core_clk);
        if (won) ara_won <= 1'b1; else ara_req <= 1'b1;
        @(posedge core_clk);
        ara_req <= 1'b0;
        ara_won <= 1'b0;
        #1;
    endtask
    task automatic ms(input logic [13:0] d, input logic [15:0] v,
                      input logic [15:0] e);
        @(posedge core_clk);
        meas <= '{1'b1, d, v};
        @(posedge core_clk);
        meas.valid <= 1'b0;
        #1;
        chk(corr_valid, 1'b1);
        chk(thermopile_voltage, e);
    endtask
    task automatic idle;
        while (bus_busy !== 1'b0 && n < 90) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(conv_restart, 1'b1);
    endtask
    // busy window: abort pulse, bus deaf, exact length
    task automatic load_chk;
        n = 0;
        while (bus_busy !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(conv_abort, 1'b1);
        i_bus_host_model.acc(1'b0, 8'h02, 16'h0000, ok);
        chk(ok, 1'b0);
        n = 2;
        idle();
        chk(n[15:0], LC[15:0]);
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        meas = '0;
        conv = '0;
        {gcall_reset, ara_req, ara_won} = 3'b000;
        void'($urandom(92));
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        n = 0;
        idle();
        rd(8'h02, 16'h1440);
        // two keyed stores around an unkeyed one, then reload
        wr(8'h06, 16'h1240);
        wr(8'h2A, 16'h6A32);
        rd(8'h2A, 16'h0030);
        wr(8'h06, 16'h2480);
        wr(8'h2A, 16'h0032);
        rd(8'h2A, 16'h0030);
        wr(8'h2A, 16'h6A32);
        rd(8'h2A, 16'h0230);
        wr(8'h06, 16'h0C80);
        wr(8'h2A, 16'h6A34);
        load_chk();
        rd(8'h06, 16'h2480);
        wr(8'h06, 16'h0C80);
        rd(8'h06, 16'h0C80);
        $display("store and load test finished");
        // window mode, pin gate off then on
        wr(8'h07, 16'h0640);
        wr(8'h05, 16'h2000);
        wr(8'h02, 16'h0000);
        cv(14'h0400);
        chk(alert_n, 1'b1);
        rd(8'h04, 16'h2000);
        wr(8'h02, 16'h0100);
        cv(14'h0400);
        chk(alert_n, 1'b0);
        ara(1'b0);
        chk(ara_ack, 1'b1);
        chk(ara_lsb, 1'b1);
        ara(1'b1);
        chk(alert_n, 1'b1);
        rd(8'h04, 16'h2000);
        rd(8'h04, 16'h0000);
        // low-limit cause answers with a zero cause bit
        wr(8'h05, 16'h1000);
        cv(14'h0100);
        ara(1'b0);
        chk(ara_lsb, 1'b0);
        // comparator with hysteresis
        wr(8'h05, 16'h3000);
        wr(8'h02, 16'h0120);
        cv(14'h0400);
        rd(8'h04, 16'hA000);
        cv(14'h0200);
        chk(alert_n, 1'b0);
        cv(14'h0100);
        chk(alert_n, 1'b1);
        rd(8'h04, 16'h0000);
        $display("alert test finished");
        @(posedge core_clk);
        gcall_reset <= 1'b1;
        @(posedge core_clk);
        gcall_reset <= 1'b0;
        #1;
        load_chk();
        rd(8'h02, 16'h1440);
        // correction after the load; first sample passes unmodified
        w = $urandom % 200;
        wr(8'h12, w[15:0]);
        ms(14'h0010, 16'h0100, 16'h0100);
        raw = $urandom % 1000;
        p = raw + ((52 * 32) >>> 8) + ((w * (raw - 256)) >>> 8);
        ms(14'h0030, raw[15:0], p[15:0]);
        wr(8'h11, 16'h0000);
        wr(8'h12, 16'h0000);
        ms(14'h0050, 16'h0200, 16'h0200);
        // output filter, one boundary sample among random ones
        for (int i = 0; i < 6; i++) begin
            raw = (i == 1) ? -2048 : int'($urandom % 4096) - 2048;
            p = (i == 0) ? raw : (raw + 4 * p) / 5;
            cv(raw[13:0]);
            rd(8'h03, {p[13:0], 2'b00});
        end
        $display("correction and filter test finished");
        test_done();
    end
endmodule
`default_nettype wire
